// ### design/lpsc_link_power.sv
// Link power state control for the chipset end of the processor link
// What this block does
// - Rx bias off when termination off, if enabled
// - Tx bias off when all lanes Hi-Z
// - First-generation tristate; all lanes tristated from reset
// - CAD and CTL tristate together, clock optional
// - Tristate enable bit 13 of tristate register
// - Training bit 8 lets clock lanes tristate
// - Third-generation: enter selected state on stop
// - Select fields: 0 is LS1, 2 is LS2
// - Gate PHY clock in LS2 when enabled
// - Power down DLLs in LS2 when enabled
// - Narrow link: unused lanes take selected state
// - Inactive code 0 warm reset, 1 PHY off
// - Stutter mode reconnects link during enhanced halt
// - Traffic mask fields pick stutter traffic
// - Inactive code 3 holds lanes in LS2
`timescale 1ns/10ps
`include "lpsc_defines.svh"
module lpsc_link_power
  import lpsc_pkg::*;
(
  input  wire logic        clk,            // Core clock
  input  wire logic        arst_n,         // Asynchronous reset
  input  wire logic        link_clk,       // Link clock
  input  wire lpsc_cfg_t   cfg_req,        // Register request
  output logic [31:0]      cfg_rdata,      // Read data
  output logic             cfg_rvalid,     // Read data valid pulse
  input  wire logic        stop_n,         // Link stop pin, active low
  input  wire logic        halt_pin,       // Processor in enhanced halt
  input  wire logic        gen3_mode,      // Third-generation link mode
  input  wire logic [4:0]  width_rx,       // Receive link width
  input  wire logic [4:0]  width_tx,       // Transmit link width
  input  wire logic [20:0] traffic_req,    // Pending traffic per class
  output logic             cad_ctl_oe,     // CAD and CTL lane drive
  output logic             clk_lane_oe,    // Clock lane drive
  output logic             rx_bias_on,     // Receiver bias on
  output logic             tx_bias_on,     // Transmitter bias on
  output logic             phy_clk_gated,  // PHY clock gated
  output logic             dll_down,       // DLLs powered down
  output logic [1:0]       rx_ls,          // Receive low-power state
  output logic [1:0]       tx_ls,          // Transmit low-power state
  output logic [1:0]       rx_inact,       // Rx inactive lane state
  output logic [1:0]       tx_inact,       // Tx inactive lane state
  output logic             rx_inact_on,    // Rx inactive lanes present
  output logic             tx_inact_on,    // Tx inactive lanes present
  output logic             reconnecting    // Stutter reconnection active
);

  // Register file
  logic [31:0] misc_stutter_control;
  logic [31:0] link_bias_dll_control;
  logic [31:0] stutter_traffic_mask_low;
  logic [31:0] stutter_traffic_mask_high;
  logic [31:0] phy_clock_gate_control;
  logic [31:0] link_training_state_select;
  logic [31:0] link_tristate_control;

  // Synchronised pins
  logic        stop_m, stop_s;
  logic        halt_m, halt_s;
  // Sequencer state and sampled choices
  lpsc_state_t state;
  lpsc_state_t next_state;
  logic        boot;
  logic        smp_tri;
  logic        smp_clk_tri;
  logic [1:0]  smp_rx_sel;
  logic [1:0]  smp_tx_sel;
  lpsc_lane_t  lane_req;
  lpsc_lane_t  next_lane;
  lpsc_lane_t  step_lane;      // Lane request moved one group per cycle
  // Link domain synchroniser
  lpsc_lane_t  lane_m;
  logic        traffic_hit;
  logic        stop_edge;
  logic        in_ls2;

  // Match a register index in a space
  function automatic logic hit(input lpsc_space_t sp, input logic [7:0] ix);
    hit = (cfg_req.space == sp) && (cfg_req.index == ix);
  endfunction : hit

  // Register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      misc_stutter_control       <= `LPSC_REG_RESET;
      link_bias_dll_control      <= `LPSC_REG_RESET;
      stutter_traffic_mask_low   <= `LPSC_REG_RESET;
      stutter_traffic_mask_high  <= `LPSC_REG_RESET;
      phy_clock_gate_control     <= `LPSC_REG_RESET;
      link_training_state_select <= `LPSC_REG_RESET;
      link_tristate_control      <= `LPSC_REG_RESET;
    end else if (cfg_req.wr) begin
      if (hit(LPSC_SPACE_MISC, `LPSC_OFS_MISC_STUTTER))
        misc_stutter_control <= cfg_req.wdata;
      if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_BIAS_DLL))
        link_bias_dll_control <= cfg_req.wdata;
      if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_LOW))
        stutter_traffic_mask_low <= cfg_req.wdata;
      if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_HIGH))
        stutter_traffic_mask_high <= cfg_req.wdata;
      if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_PHY_GATE))
        phy_clock_gate_control <= cfg_req.wdata;
      if (hit(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL))
        link_training_state_select <= cfg_req.wdata;
      if (hit(LPSC_SPACE_CFG, `LPSC_OFS_TRISTATE))
        link_tristate_control <= cfg_req.wdata;
    end
  end

  // Register reads, unmapped index reads zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_req.rd;
      if (hit(LPSC_SPACE_MISC, `LPSC_OFS_MISC_STUTTER))
        cfg_rdata <= misc_stutter_control;
      else if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_BIAS_DLL))
        cfg_rdata <= link_bias_dll_control;
      else if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_LOW))
        cfg_rdata <= stutter_traffic_mask_low;
      else if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_HIGH))
        cfg_rdata <= stutter_traffic_mask_high;
      else if (hit(LPSC_SPACE_UNIT, `LPSC_OFS_PHY_GATE))
        cfg_rdata <= phy_clock_gate_control;
      else if (hit(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL))
        cfg_rdata <= link_training_state_select;
      else if (hit(LPSC_SPACE_CFG, `LPSC_OFS_TRISTATE))
        cfg_rdata <= link_tristate_control;
      else
        cfg_rdata <= 32'h0000_0000;
    end
  end

  // Two-flop synchronisers for the pins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_m <= 1'b1;
      stop_s <= 1'b1;
      halt_m <= 1'b0;
      halt_s <= 1'b0;
    end else begin
      stop_m <= stop_n;
      stop_s <= stop_m;
      halt_m <= halt_pin;
      halt_s <= halt_m;
    end
  end

  // Stop assertion seen while active; masked stutter traffic
  assign stop_edge   = (state == LPSC_ACTIVE) && !stop_s;
  assign traffic_hit = |(traffic_req & {
    stutter_traffic_mask_high[`LPSC_MASK_HI_MSB:`LPSC_MASK_HI_LSB],
    stutter_traffic_mask_low[`LPSC_MASK_LO_MSB:`LPSC_MASK_LO_LSB]});
  assign in_ls2 = (state == LPSC_LOWPWR) && gen3_mode &&
                  (smp_rx_sel == LPSC_LS2) && (smp_tx_sel == LPSC_LS2);

  // Sample selections at stop assertion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_tri     <= 1'b0;
      smp_clk_tri <= 1'b0;
      smp_rx_sel  <= 2'h0;
      smp_tx_sel  <= 2'h0;
    end else if (stop_edge) begin
      smp_tri     <= link_tristate_control[`LPSC_BIT_TRI_EN];
      smp_clk_tri <= link_training_state_select[`LPSC_BIT_CLK_TRI];
      smp_rx_sel  <= link_training_state_select[`LPSC_RX_SEL_MSB:`LPSC_RX_SEL_LSB];
      smp_tx_sel  <= link_training_state_select[`LPSC_TX_SEL_MSB:`LPSC_TX_SEL_LSB];
    end
  end

  // Next sequencer state
  always_comb begin
    next_state = state;
    unique case (state)
      LPSC_ACTIVE: begin
        if (!stop_s)
          next_state = LPSC_LOWPWR;
      end
      LPSC_LOWPWR: begin
        if (stop_s)
          next_state = LPSC_ACTIVE;
        else if (misc_stutter_control[`LPSC_BIT_STUTTER_EN] && halt_s && traffic_hit)
          next_state = LPSC_RECONN;
      end
      LPSC_RECONN: begin
        if (stop_s)
          next_state = LPSC_ACTIVE;
        else if (!traffic_hit)
          next_state = LPSC_LOWPWR;
      end
      default: next_state = LPSC_ACTIVE;
    endcase
  end

  // Sequencer state and boot flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= LPSC_ACTIVE;
      boot  <= 1'b1;
    end else begin
      state <= next_state;
      if (stop_s)
        boot <= 1'b0;
    end
  end

  // Lane drive request: CAD and CTL share one enable
  always_comb begin
    next_lane = '{cad_ctl_oe: 1'b1, clk_oe: 1'b1};
    if (boot) begin
      next_lane = '{cad_ctl_oe: 1'b0, clk_oe: 1'b0};
    end else if (state == LPSC_LOWPWR) begin
      if (gen3_mode) begin
        next_lane.cad_ctl_oe = 1'b0;
        next_lane.clk_oe     = (smp_tx_sel == LPSC_LS1);
      end else if (smp_tri) begin
        next_lane.cad_ctl_oe = 1'b0;
        next_lane.clk_oe     = !smp_clk_tri;
      end
    end
  end

  // One lane group changes per core cycle, so the link side never sees
  // CAD and CTL driven with the clock lanes off while both enables cross
  always_comb begin
    step_lane = next_lane;
    if ((next_lane.cad_ctl_oe != lane_req.cad_ctl_oe) && (next_lane.clk_oe != lane_req.clk_oe)) begin
      step_lane = '{cad_ctl_oe: 1'b0, clk_oe: 1'b1};
    end
  end

  // Power controls for bias, clocks and DLLs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_req      <= '{cad_ctl_oe: 1'b0, clk_oe: 1'b0};
      rx_bias_on    <= 1'b1;
      tx_bias_on    <= 1'b1;
      phy_clk_gated <= 1'b0;
      dll_down      <= 1'b0;
      reconnecting  <= 1'b0;
    end else begin
      lane_req      <= step_lane;
      rx_bias_on    <= !(link_bias_dll_control[`LPSC_BIT_RX_BIAS] &&
                         !step_lane.cad_ctl_oe);
      tx_bias_on    <= !(link_bias_dll_control[`LPSC_BIT_TX_BIAS] &&
                         !step_lane.cad_ctl_oe && !step_lane.clk_oe);
      phy_clk_gated <= in_ls2 && phy_clock_gate_control[`LPSC_BIT_PHY_GATE];
      dll_down      <= in_ls2 && link_bias_dll_control[`LPSC_BIT_DLL_PD];
      reconnecting  <= (next_state == LPSC_RECONN);
    end
  end

  // Reported low-power state and inactive lanes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_ls       <= LPSC_LS0;
      tx_ls       <= LPSC_LS0;
      rx_inact    <= LPSC_IN_WARM;
      tx_inact    <= LPSC_IN_WARM;
      rx_inact_on <= 1'b0;
      tx_inact_on <= 1'b0;
    end else begin
      rx_ls <= (state == LPSC_LOWPWR && gen3_mode) ? smp_rx_sel : LPSC_LS0;
      tx_ls <= (state == LPSC_LOWPWR && gen3_mode) ? smp_tx_sel : LPSC_LS0;
      rx_inact_on <= width_rx < `LPSC_FULL_WIDTH;
      tx_inact_on <= width_tx < `LPSC_FULL_WIDTH;
      rx_inact <= link_training_state_select[`LPSC_RX_INACT_MSB:`LPSC_RX_INACT_LSB];
      tx_inact <= link_training_state_select[`LPSC_TX_INACT_MSB:`LPSC_TX_INACT_LSB];
    end
  end

  // Link domain: lane enables cross as slow levels, tristated under reset
  always_ff @(posedge link_clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_m      <= '{cad_ctl_oe: 1'b0, clk_oe: 1'b0};
      cad_ctl_oe  <= 1'b0;
      clk_lane_oe <= 1'b0;
    end else begin
      lane_m      <= lane_req;
      cad_ctl_oe  <= lane_m.cad_ctl_oe;
      clk_lane_oe <= lane_m.clk_oe;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rx_bias_off: assert property (
    link_bias_dll_control[`LPSC_BIT_RX_BIAS] && !lane_req.cad_ctl_oe |-> !rx_bias_on)
    else $error("rx bias on with termination off");
  a_tx_bias_off: assert property (
    !lane_req.cad_ctl_oe && !lane_req.clk_oe && link_bias_dll_control[`LPSC_BIT_TX_BIAS]
    |-> !tx_bias_on) else $error("tx bias on with lanes Hi-Z");
  a_lane_group: assert property (
    lane_req.cad_ctl_oe |-> lane_req.clk_oe) else $error("CAD and CTL driven with clock lanes off");
  a_boot_tristate: assert property (
    boot |-> ##1 !lane_req.cad_ctl_oe) else $error("lanes driven before start");
  a_gen1_clk_keep: assert property (
    state == LPSC_LOWPWR && !gen3_mode && !boot && smp_tri && !smp_clk_tri
    |=> lane_req.clk_oe) else $error("clock lanes tristated while kept");
  a_enter_lowpwr: assert property (
    state == LPSC_ACTIVE && !stop_s |=> state == LPSC_LOWPWR)
    else $error("stop assertion not entered");
  a_ls2_gate: assert property (
    in_ls2 && phy_clock_gate_control[`LPSC_BIT_PHY_GATE]
    && $stable(phy_clock_gate_control) |=> phy_clk_gated) else $error("PHY clock not gated");
  a_ls2_dll: assert property (
    !in_ls2 |=> !dll_down) else $error("DLL down outside LS2");
  a_narrow_lane: assert property (
    width_tx < `LPSC_FULL_WIDTH |=> tx_inact_on) else $error("narrow tx not flagged");
  a_stutter_reconn: assert property (
    state == LPSC_LOWPWR && stop_s == 1'b0 && halt_s && traffic_hit
    && misc_stutter_control[`LPSC_BIT_STUTTER_EN] |=> reconnecting)
    else $error("stutter reconnect missed");
  a_sample_hold: assert property (
    state != LPSC_ACTIVE |=> $stable(smp_rx_sel) && $stable(smp_tri))
    else $error("selection changed during low power");
  c_gen3_ls2: cover property (in_ls2 ##1 phy_clk_gated);
  c_stutter: cover property (state == LPSC_RECONN ##1 state == LPSC_LOWPWR);
  c_gen1_tri: cover property (!gen3_mode && state == LPSC_LOWPWR && !lane_req.clk_oe);

endmodule : lpsc_link_power

// ### design/lpsc_defines.svh
// Register offsets, field positions, register reset value and full link width for the link power block
`ifndef LPSC_DEFINES_SVH
`define LPSC_DEFINES_SVH
// Register indexes within their index spaces
`define LPSC_OFS_MISC_STUTTER  8'h0C
`define LPSC_OFS_BIAS_DLL      8'h15
`define LPSC_OFS_MASK_LOW      8'h16
`define LPSC_OFS_MASK_HIGH     8'h1C
`define LPSC_OFS_PHY_GATE      8'h4B
`define LPSC_OFS_TRAIN_SEL     8'hAC
`define LPSC_OFS_TRISTATE      8'hC8
// Field positions
`define LPSC_BIT_RX_BIAS       31
`define LPSC_BIT_TX_BIAS       30
`define LPSC_BIT_DLL_PD        27
`define LPSC_BIT_PHY_GATE      11
`define LPSC_BIT_TRI_EN        13
`define LPSC_BIT_CLK_TRI       8
`define LPSC_BIT_STUTTER_EN    13
`define LPSC_RX_SEL_MSB        8
`define LPSC_RX_SEL_LSB        7
`define LPSC_TX_SEL_MSB        22
`define LPSC_TX_SEL_LSB        21
`define LPSC_RX_INACT_MSB      24
`define LPSC_RX_INACT_LSB      23
`define LPSC_TX_INACT_MSB      26
`define LPSC_TX_INACT_LSB      25
`define LPSC_MASK_HI_MSB       31
`define LPSC_MASK_HI_LSB       17
`define LPSC_MASK_LO_MSB       15
`define LPSC_MASK_LO_LSB       10
// Register reset value
`define LPSC_REG_RESET         32'h0000_0000
// Link widths
`define LPSC_FULL_WIDTH        5'h10
`endif

// ### design/lpsc_pkg.sv
// Types shared by the link power block
package lpsc_pkg;
  // Index spaces holding the registers
  typedef enum logic [1:0] {
    LPSC_SPACE_CFG  = 2'h0,
    LPSC_SPACE_UNIT = 2'h1,
    LPSC_SPACE_MISC = 2'h2
  } lpsc_space_t;
  // Low-power state codes
  typedef enum logic [1:0] {
    LPSC_LS1 = 2'h0,
    LPSC_LS3 = 2'h1,
    LPSC_LS2 = 2'h2,
    LPSC_LS0 = 2'h3
  } lpsc_ls_t;
  // Inactive lane codes
  typedef enum logic [1:0] {
    LPSC_IN_WARM = 2'h0,
    LPSC_IN_OFF  = 2'h1,
    LPSC_IN_RSV  = 2'h2,
    LPSC_IN_LS2  = 2'h3
  } lpsc_inact_t;
  // Link power sequencer states
  typedef enum logic [2:0] {
    LPSC_ACTIVE = 3'b001,
    LPSC_LOWPWR = 3'b010,
    LPSC_RECONN = 3'b100
  } lpsc_state_t;
  // Lane drive enables handed to the link clock domain
  typedef struct packed {
    logic cad_ctl_oe;
    logic clk_oe;
  } lpsc_lane_t;
  // Configuration request
  typedef struct packed {
    logic        wr;
    logic        rd;
    lpsc_space_t space;
    logic [7:0]  index;
    logic [31:0] wdata;
  } lpsc_cfg_t;
endpackage : lpsc_pkg

// ### verif/lpsc_host_model.sv
// Host processor model at the far end of the link
`timescale 1ns/10ps
module lpsc_host_model
  import lpsc_pkg::*;
(
  input  wire logic        clk,          // Core clock
  input  wire logic        arst_n,       // Reset, active low
  input  wire logic        want_stop,    // Ask for low power
  input  wire logic        want_halt,    // Enter enhanced halt
  input  wire logic [20:0] want_traffic, // DMA traffic per class
  input  wire logic        tri_en,       // Own tristate enable
  input  wire logic        clk_tri,      // Own clock tristate enable
  output logic             stop_n,       // Link stop pin, active low
  output logic             halt_pin,     // Halt indication
  output logic [20:0]      traffic_req,  // Pending traffic
  output logic             host_clk_oe   // Own clock lane drive
);
  // Pins move just after the falling edge, idle high stop
  always_ff @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_n      <= 1'b1;
      halt_pin    <= 1'b0;
      traffic_req <= 21'h000000;
    end else begin
      stop_n      <= !want_stop;
      halt_pin    <= want_halt;
      traffic_req <= want_traffic;
    end
  end
  // Own clock lanes follow the same tristate choice as the device
  assign host_clk_oe = !(!stop_n && tri_en && clk_tri);
endmodule : lpsc_host_model

// ### verif/lpsc_link_power_test.sv
// Self-checking bench for the link power block
`timescale 1ns/10ps
`include "lpsc_defines.svh"
module lpsc_link_power_test
  import lpsc_pkg::*;
;
  logic        clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0;
  lpsc_cfg_t   cfg_req = '0;
  logic [31:0] cfg_rdata;
  logic        cfg_rvalid, stop_n, halt_pin, gen3_mode = 1'b0;
  logic        want_stop = 1'b0, want_halt = 1'b0, tri_en = 1'b0, clk_tri = 1'b0;
  logic [20:0] want_traffic = '0, traffic_req;
  logic [4:0]  width_rx = 5'h10, width_tx = 5'h10;
  logic        cad_ctl_oe, clk_lane_oe, rx_bias_on, tx_bias_on, phy_clk_gated, dll_down;
  logic        rx_inact_on, tx_inact_on, reconnecting, host_clk_oe;
  logic [1:0]  rx_ls, tx_ls, rx_inact, tx_inact;
  int          fails = 0, num_checks = 0;
  logic [15:0] seed = 16'h0043;
  // Register map walked for reset and readback
  lpsc_space_t sp_tab [7] = '{LPSC_SPACE_MISC, LPSC_SPACE_UNIT, LPSC_SPACE_UNIT, LPSC_SPACE_UNIT,
                              LPSC_SPACE_UNIT, LPSC_SPACE_CFG, LPSC_SPACE_CFG};
  logic [7:0]  ix_tab [7] = '{`LPSC_OFS_MISC_STUTTER, `LPSC_OFS_BIAS_DLL, `LPSC_OFS_MASK_LOW,
                              `LPSC_OFS_MASK_HIGH, `LPSC_OFS_PHY_GATE, `LPSC_OFS_TRAIN_SEL, `LPSC_OFS_TRISTATE};
  logic [1:0]  ic_tab [3] = '{2'h0, 2'h1, 2'h3};
  // Core clock, and a link clock of unrelated phase
  always #25 clk = ~clk;
  initial begin
    #7;
    forever #62.5 link_clk = ~link_clk;
  end
  lpsc_link_power DUT (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .stop_n(stop_n), .halt_pin(halt_pin),
    .gen3_mode(gen3_mode), .width_rx(width_rx), .width_tx(width_tx), .traffic_req(traffic_req),
    .cad_ctl_oe(cad_ctl_oe), .clk_lane_oe(clk_lane_oe), .rx_bias_on(rx_bias_on),
    .tx_bias_on(tx_bias_on), .phy_clk_gated(phy_clk_gated), .dll_down(dll_down), .rx_ls(rx_ls),
    .tx_ls(tx_ls), .rx_inact(rx_inact), .tx_inact(tx_inact), .rx_inact_on(rx_inact_on),
    .tx_inact_on(tx_inact_on), .reconnecting(reconnecting));
  lpsc_host_model host (.clk(clk), .arst_n(arst_n), .want_stop(want_stop), .want_halt(want_halt),
    .want_traffic(want_traffic), .tri_en(tri_en), .clk_tri(clk_tri), .stop_n(stop_n),
    .halt_pin(halt_pin), .traffic_req(traffic_req), .host_clk_oe(host_clk_oe));
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Expected clock lane drive while stopped
  function automatic logic clk_kept(input logic g3, input logic [1:0] sel, input logic ck);
    return g3 ? (sel == LPSC_LS1) : !ck;
  endfunction : clk_kept
  function automatic logic [31:0] sel_word(input logic [1:0] x);
    return {9'h0, x, 12'h0, x, 7'h0};
  endfunction : sel_word
  // One write pulse, then one idle cycle
  task automatic cfg_wr(input lpsc_space_t sp, input logic [7:0] ix, input logic [31:0] d);
    @(negedge clk);
    cfg_req = '{wr: 1'b1, rd: 1'b0, space: sp, index: ix, wdata: d};
    @(negedge clk);
    cfg_req = '0;
  endtask : cfg_wr
  // Read pulse; answer stands in the following cycle
  task automatic cfg_rd(input lpsc_space_t sp, input logic [7:0] ix, input logic [31:0] exp);
    @(negedge clk);
    cfg_req = '{wr: 1'b0, rd: 1'b1, space: sp, index: ix, wdata: 32'h0};
    @(negedge clk);
    cfg_req = '0;
    check(cfg_rvalid, 1'b1);
    check(cfg_rdata, exp);
  endtask : cfg_rd
  // Move the stop pin and let both synchronisers settle
  task automatic link_stop(input logic v);
    want_stop = v;
    repeat (12) @(negedge clk);
  endtask : link_stop
  initial begin
    repeat (16) @(negedge clk);
    check(cad_ctl_oe, 1'b0);
    check(clk_lane_oe, 1'b0);
    arst_n = 1'b1;
    link_stop(1'b0);
    check(cad_ctl_oe, 1'b1);
    // Reset values, random readback, then clear
    for (int i = 0; i < 7; i++) begin
      cfg_rd(sp_tab[i], ix_tab[i], `LPSC_REG_RESET);
      seed = lfsr(seed);
      cfg_wr(sp_tab[i], ix_tab[i], {seed, ~seed});
      cfg_rd(sp_tab[i], ix_tab[i], {seed, ~seed});
      cfg_wr(sp_tab[i], ix_tab[i], 32'h0);
    end
    cfg_wr(lpsc_space_t'(2'h3), 8'h55, 32'hFFFFFFFF);
    cfg_rd(lpsc_space_t'(2'h3), 8'h55, 32'h0);
    cfg_rd(LPSC_SPACE_CFG, `LPSC_OFS_BIAS_DLL, 32'h0);
    // First generation: off, CAD and CTL, CAD CTL and clock
    cfg_wr(LPSC_SPACE_UNIT, `LPSC_OFS_BIAS_DLL, 32'hC000_0000);
    for (int c = 0; c < 3; c++) begin
      tri_en = (c != 0);
      clk_tri = (c == 2);
      cfg_wr(LPSC_SPACE_CFG, `LPSC_OFS_TRISTATE, {18'h0, tri_en, 13'h0});
      cfg_wr(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL, {23'h0, clk_tri, 8'h0});
      link_stop(1'b1);
      check(cad_ctl_oe, !tri_en);
      check(clk_lane_oe, clk_kept(1'b0, 2'h0, clk_tri));
      check(clk_lane_oe, host_clk_oe);
      check(rx_bias_on, !tri_en);
      check(tx_bias_on, !clk_tri);
      link_stop(1'b0);
      check(cad_ctl_oe, 1'b1);
    end
    // Third generation: LS1 and LS2, select rewritten while stopped
    gen3_mode = 1'b1;
    cfg_wr(LPSC_SPACE_UNIT, `LPSC_OFS_PHY_GATE, 32'h0000_0800);
    cfg_wr(LPSC_SPACE_UNIT, `LPSC_OFS_BIAS_DLL, 32'hC800_0000);
    for (int s = 0; s < 4; s += 2) begin
      cfg_wr(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL, sel_word(s[1:0]));
      link_stop(1'b1);
      cfg_wr(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL, sel_word(2'h2 - s[1:0]));
      repeat (4) @(negedge clk);
      check(rx_ls, s[1:0]);
      check(tx_ls, s[1:0]);
      check(phy_clk_gated, s == 2);
      check(dll_down, s == 2);
      check(cad_ctl_oe, 1'b0);
      check(clk_lane_oe, clk_kept(1'b1, s[1:0], 1'b0));
      check(tx_bias_on, s == 0);
      link_stop(1'b0);
      check(rx_ls, 2'h3);
    end
    // Narrow links and inactive lane codes 0, 1 and 3
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      width_rx = (k == 0) ? 5'h0F : (seed[4:0] > 5'h10 ? 5'h10 : seed[4:0]);
      width_tx = (k == 1) ? 5'h10 : {1'b0, seed[8:5]};
      cfg_wr(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL, {5'h0, ic_tab[(k + 1) % 3], ic_tab[k % 3], 23'h0});
      repeat (2) @(negedge clk);
      check(rx_inact, ic_tab[k % 3]);
      check(tx_inact, ic_tab[(k + 1) % 3]);
      check(rx_inact_on, width_rx < 5'h10);
      check(tx_inact_on, width_tx < 5'h10);
    end
    width_rx = 5'h10;
    width_tx = 5'h10;
    // Stutter reconnection during enhanced halt in LS2
    cfg_wr(LPSC_SPACE_MISC, `LPSC_OFS_MISC_STUTTER, 32'h0000_2000);
    cfg_wr(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_HIGH, 32'hFFFE_0000);
    cfg_wr(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_LOW, 32'h0000_FC00);
    cfg_wr(LPSC_SPACE_CFG, `LPSC_OFS_TRAIN_SEL, sel_word(LPSC_LS2));
    want_halt = 1'b1;
    link_stop(1'b1);
    check(reconnecting, 1'b0);
    for (int t = 0; t < 3; t++) begin
      seed = lfsr(seed);
      want_traffic = 21'h1 << ((t == 0) ? 20 : (t == 1) ? 0 : int'(seed[3:0]));
      repeat (12) @(negedge clk);
      check(reconnecting, 1'b1);
      check(cad_ctl_oe, 1'b1);
      want_traffic = '0;
      repeat (12) @(negedge clk);
      check(reconnecting, 1'b0);
    end
    cfg_wr(LPSC_SPACE_UNIT, `LPSC_OFS_MASK_HIGH, 32'h0);
    want_traffic = 21'h100000;
    repeat (12) @(negedge clk);
    check(reconnecting, 1'b0);
    want_traffic = '0;
    want_halt = 1'b0;
    link_stop(1'b0);
    // Reset again while the link runs: lanes drop, stutter control register reads its reset value
    arst_n = 1'b0;
    repeat (6) @(negedge clk);
    check(cad_ctl_oe, 1'b0);
    check(clk_lane_oe, 1'b0);
    arst_n = 1'b1;
    cfg_rd(LPSC_SPACE_MISC, `LPSC_OFS_MISC_STUTTER, `LPSC_REG_RESET);
    link_stop(1'b0);
    check(cad_ctl_oe, 1'b1);
    give_verdict;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    fails++;
    give_verdict;
  end
endmodule : lpsc_link_power_test
